// ===== design/pesc_config_top.sv
`timescale 1ns/10ps
module pesc_config_top (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Configuration port
   input  wire logic [7:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWrEn,
   input  wire logic              regRdEn,
   output      logic [7:0]        regRdData,
   output      logic              regRdValid,
   // PLL and input monitor events
   input  wire logic [3:0]        pllUnlockEvt,
   input  wire logic [3:0]        holdoverHoldEvt,
   input  wire logic [3:0]        clkLossEvt,
   input  wire logic [3:0]        clkDriftEvt,
   input  wire logic [7:0]        pllLiveStatus,
   input  wire logic [7:0]        clkMonLive,
   // General pins
   input  wire logic              generalPinFirstIn,
   output      logic              generalPinFirstOut,
   output      logic              generalPinFirstOe_n,
   input  wire logic              generalPinSecondIn,
   output      logic              generalPinSecondOut,
   output      logic              generalPinSecondOe_n,
   // Start-up controls
   output      logic              manualWakeSel,
   output      pesc_pkg::pesc_supply_e defaultSupplyLevel,
   output      logic [3:0]        pllEnable_n,
   output      logic              holdoverMapEn,
   output      logic [7:0]        fusePagePtr
);
   import pesc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] pllEn_q,   pllEn_d;     // Enable and wake-up config
   logic [7:0] pinCfg_q,  pinCfg_d;    // Pin configuration
   logic [7:0] spare_q,   spare_d;     // Spare, holdover mapping
   logic [7:0] fusePtr_q, fusePtr_d;   // One-hot fuse page pointer
   logic [7:0] pllMask_q, pllMask_d;   // PLL flag generation mask
   logic [7:0] monMask_q, monMask_d;   // Monitor flag generation mask
   logic [7:0] rdData_q,  rdData_d;    // Read data
   logic       rdValid_q, rdValid_d;   // Read answer strobe
   logic       firstOut_q,  firstOut_d;   // First pin level
   logic       firstOe_q,   firstOe_d;    // First pin enable, low drives
   logic       secondOut_q, secondOut_d;  // Second pin level
   logic       secondOe_q,  secondOe_d;   // Second pin enable, low drives

   // Summary terms
   logic       orPll;        // Any PLL flag
   logic       orMon;        // Any monitor flag
   logic       orLive;       // Any live monitor status
   logic       fuseOk;       // Write is a legal one-hot page

   // Flag groups
   pesc_flag_if #(.WIDTH(8)) pllIf ();
   pesc_flag_if #(.WIDTH(8)) monIf ();

   ////////////////////////////////////////////////////////////////////////
   // Flag banks; bit order matches the live status layout:
   // holdover D..A in 7:4, unlock D..A in 3:0 (drift and loss likewise)
   assign pllIf.events = {holdoverHoldEvt, pllUnlockEvt};
   assign pllIf.mask   = pllMask_q;
   assign pllIf.clear  = (regWrEn && regAddr == PESC_PLL_NOTIFY_ADDR)
                         ? regWrData : 8'h00;
   assign monIf.events = {clkDriftEvt, clkLossEvt};
   assign monIf.mask   = monMask_q;
   assign monIf.clear  = (regWrEn && regAddr == PESC_MON_NOTIFY_ADDR)
                         ? regWrData : 8'h00;

   // PLL lock loss and holdover flags
   pesc_flag_bank #(
      .WIDTH   (8),
      .RST_VAL (PESC_NOTIFY_RST)
   ) u_pllFlags (
      .clock   (clock),
      .rst_n   (rst_n),
      .flagIf  (pllIf)
   );

   // Input clock loss and drift flags
   pesc_flag_bank #(
      .WIDTH   (8),
      .RST_VAL (PESC_NOTIFY_RST)
   ) u_monFlags (
      .clock   (clock),
      .rst_n   (rst_n),
      .flagIf  (monIf)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_comb begin
      pllEn_d   = pllEn_q;
      pinCfg_d  = pinCfg_q;
      spare_d   = spare_q;
      fusePtr_d = fusePtr_q;
      pllMask_d = pllMask_q;
      monMask_d = monMask_q;
      fuseOk    = ($countones(regWrData) == 1) &&
                  !regWrData[PESC_FUSE_PAGE4_BIT];
      if (regWrEn) begin
         case (regAddr)
            PESC_PLL_EN_ADDR: begin
               pllEn_d = regWrData;
            end
            PESC_PIN_CFG_ADDR: begin
               pinCfg_d = regWrData;
            end
            PESC_SPARE_ADDR: begin
               spare_d = regWrData;
            end
            PESC_FUSE_PTR_ADDR: begin
               // Illegal pointer keeps the old page
               if (fuseOk) begin
                  fusePtr_d = regWrData;
               end
            end
            PESC_PLL_MASK_ADDR: begin
               pllMask_d = regWrData;
            end
            PESC_MON_MASK_ADDR: begin
               monMask_d = regWrData;
            end
            default: begin
               // Unmapped or read-only address, write ignored; a notify address write only clears flags
            end
         endcase
      end
   end

   // Register the configuration
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pllEn_q   <= PESC_PLL_EN_RST;
         pinCfg_q  <= PESC_PIN_CFG_RST;
         spare_q   <= PESC_SPARE_RST;
         fusePtr_q <= PESC_FUSE_PTR_RST;
         pllMask_q <= PESC_MASK_RST;
         monMask_q <= PESC_MASK_RST;
      end else begin
         pllEn_q   <= pllEn_d;
         pinCfg_q  <= pinCfg_d;
         spare_q   <= spare_d;
         fusePtr_q <= fusePtr_d;
         pllMask_q <= pllMask_d;
         monMask_q <= monMask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, answered one cycle after the strobe
   always_comb begin
      rdValid_d = regRdEn;
      rdData_d  = rdData_q;
      if (regRdEn) begin
         case (regAddr)
            PESC_PLL_LIVE_ADDR:   rdData_d = pllLiveStatus;
            PESC_PLL_NOTIFY_ADDR: rdData_d = pllIf.flags;
            PESC_PLL_MASK_ADDR:   rdData_d = pllMask_q;
            PESC_MON_NOTIFY_ADDR: rdData_d = monIf.flags;
            PESC_MON_MASK_ADDR:   rdData_d = monMask_q;
            PESC_PIN_LEVEL_ADDR:  rdData_d = {6'h00, generalPinSecondIn,
                                              generalPinFirstIn};
            PESC_PLL_EN_ADDR:     rdData_d = pllEn_q;
            PESC_PIN_CFG_ADDR:    rdData_d = pinCfg_q;
            PESC_SPARE_ADDR:      rdData_d = spare_q;
            PESC_FUSE_PTR_ADDR:   rdData_d = fusePtr_q;
            // Unmapped address reads as zero
            default:              rdData_d = 8'h00;
         endcase
      end
   end

   // Register the read answer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q  <= 8'h00;
         rdValid_q <= 1'b0;
      end else begin
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin source selection
   function automatic logic pinSource(input logic [2:0] sel,
                                      input logic       allOr,
                                      input logic       pllOr,
                                      input logic       monOr,
                                      input logic       liveOr);
      logic level;
      level = 1'b0;
      case (pesc_sel_e'(sel))
         PESC_SEL_LOW:    level = 1'b0;
         PESC_SEL_ALL:    level = allOr;
         PESC_SEL_PLL:    level = pllOr;
         PESC_SEL_CLKMON: level = monOr;
         PESC_SEL_LIVE:   level = liveOr;
         // Debug codes drive low; nothing internal is exposed
         default:         level = 1'b0;
      endcase
      return level;
   endfunction

   // Summaries and pin next state
   always_comb begin
      orPll  = |pllIf.flags;
      orMon  = |monIf.flags;
      orLive = |clkMonLive;
      firstOut_d  = pinSource(pinCfg_q[PESC_FIRST_SEL_HI:PESC_FIRST_SEL_LO],
                              orPll | orMon, orPll, orMon, orLive);
      secondOut_d = pinSource(
                       pinCfg_q[PESC_SECOND_SEL_HI:PESC_SECOND_SEL_LO],
                       orPll | orMon, orPll, orMon, orLive);
      firstOe_d   = !pinCfg_q[PESC_FIRST_DIR_BIT];
      secondOe_d  = !pinCfg_q[PESC_SECOND_DIR_BIT];
      if (firstOe_d) begin
         firstOut_d = 1'b0;
      end
      if (secondOe_d) begin
         secondOut_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         firstOut_q  <= 1'b0;
         firstOe_q   <= 1'b1;
         secondOut_q <= 1'b0;
         secondOe_q  <= 1'b1;
      end else begin
         firstOut_q  <= firstOut_d;
         firstOe_q   <= firstOe_d;
         secondOut_q <= secondOut_d;
         secondOe_q  <= secondOe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops except manualWakeSel, which is an inverted flip-flop bit
   assign regRdData            = rdData_q;
   assign regRdValid           = rdValid_q;
   assign generalPinFirstOut   = firstOut_q;
   assign generalPinFirstOe_n  = firstOe_q;
   assign generalPinSecondOut  = secondOut_q;
   assign generalPinSecondOe_n = secondOe_q;
   assign manualWakeSel        = !pllEn_q[PESC_WAKE_SEL_BIT];
   assign defaultSupplyLevel   =
      pesc_supply_e'(pllEn_q[PESC_SUPPLY_HI:PESC_SUPPLY_LO]);
   assign pllEnable_n          = pllEn_q[PESC_PLL_EN_HI:PESC_PLL_EN_LO];
   assign holdoverMapEn        = spare_q[PESC_HOLD_MAP_BIT];
   assign fusePagePtr          = fusePtr_q;

endmodule

// ===== design/pesc_flag_bank.sv
`timescale 1ns/10ps
// Bank of sticky notify flags with generation mask
module pesc_flag_bank #(
   parameter int            WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic   clock,
   input  wire logic   rst_n,
   // Flag group
   pesc_flag_if.bank   flagIf
);
   import pesc_pkg::*;

   // Width the logic can serve, refused while the design is elaborated
   if (WIDTH < 1 || WIDTH > 8) begin : g_widthCheck
      $error("pesc_flag_bank: WIDTH must be 1 to 8");
   end

   logic [WIDTH-1:0] flags_q;    // Sticky state
   logic [WIDTH-1:0] flags_d;    // Next sticky state

   ////////////////////////////////////////////////////////////////////////
   // Next state: a set in the same cycle as a clear wins, so no event
   // is lost while software is acknowledging an older one
   always_comb begin
      flags_d = (flags_q & ~flagIf.clear) | (flagIf.events & flagIf.mask);
   end

   // Register the flags
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_VAL;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flagIf.flags = flags_q;

endmodule

// ===== pkg/pesc_flag_if.sv
`timescale 1ns/10ps
// Sticky flag group carrier between the register core and a flag bank
interface pesc_flag_if #(
   parameter int WIDTH = 8
);
   logic [WIDTH-1:0] events;     // Event pulses or levels from monitors
   logic [WIDTH-1:0] mask;       // One lets a flag be generated
   logic [WIDTH-1:0] clear;      // One-cycle clear strobes
   logic [WIDTH-1:0] flags;      // Sticky flag state

   modport bank (
      input  events,
      input  mask,
      input  clear,
      output flags
   );
   modport ctrl (
      output events,
      output mask,
      output clear,
      input  flags
   );
endinterface

// ===== pkg/pesc_pkg.sv
package pesc_pkg;

   // Register offsets on the configuration port
   localparam logic [7:0] PESC_PLL_LIVE_ADDR    = 8'h06;
   localparam logic [7:0] PESC_PLL_NOTIFY_ADDR  = 8'h07;
   localparam logic [7:0] PESC_PLL_MASK_ADDR    = 8'h08;
   localparam logic [7:0] PESC_MON_NOTIFY_ADDR  = 8'h09;
   localparam logic [7:0] PESC_MON_MASK_ADDR    = 8'h0a;
   localparam logic [7:0] PESC_PIN_LEVEL_ADDR   = 8'h0b;
   localparam logic [7:0] PESC_PLL_EN_ADDR      = 8'h10;
   localparam logic [7:0] PESC_PIN_CFG_ADDR     = 8'h18;
   localparam logic [7:0] PESC_SPARE_ADDR       = 8'h19;
   localparam logic [7:0] PESC_FUSE_PTR_ADDR    = 8'h22;

   // Values after reset
   localparam logic [7:0] PESC_PLL_EN_RST       = 8'h00;
   localparam logic [7:0] PESC_PIN_CFG_RST      = 8'h00;
   localparam logic [7:0] PESC_SPARE_RST        = 8'h00;
   localparam logic [7:0] PESC_FUSE_PTR_RST     = 8'h00;
   localparam logic [7:0] PESC_NOTIFY_RST       = 8'hff;
   localparam logic [7:0] PESC_MASK_RST         = 8'hff;

   // Field positions, enable register
   localparam int PESC_WAKE_SEL_BIT   = 6;
   localparam int PESC_SUPPLY_HI      = 5;
   localparam int PESC_SUPPLY_LO      = 4;
   localparam int PESC_PLL_EN_HI      = 3;
   localparam int PESC_PLL_EN_LO      = 0;

   // Field positions, pin configuration register
   localparam int PESC_FIRST_DIR_BIT  = 7;
   localparam int PESC_FIRST_SEL_HI   = 6;
   localparam int PESC_FIRST_SEL_LO   = 4;
   localparam int PESC_SECOND_DIR_BIT = 3;
   localparam int PESC_SECOND_SEL_HI  = 2;
   localparam int PESC_SECOND_SEL_LO  = 0;

   // Field position, spare register
   localparam int PESC_HOLD_MAP_BIT   = 6;

   // Fuse pointer bit of the reserved page
   localparam int PESC_FUSE_PAGE4_BIT = 4;

   // Supply level encodings
   typedef enum logic [1:0] {
      PESC_SUPPLY_1V8 = 2'h0,
      PESC_SUPPLY_2V5 = 2'h1,
      PESC_SUPPLY_3V3 = 2'h2
   } pesc_supply_e;

   // Pin source select codes
   typedef enum logic [2:0] {
      PESC_SEL_LOW     = 3'h0,
      PESC_SEL_ALL     = 3'h1,
      PESC_SEL_PLL     = 3'h2,
      PESC_SEL_CLKMON  = 3'h3,
      PESC_SEL_LIVE    = 3'h4,
      PESC_SEL_DEBUG5  = 3'h5,
      PESC_SEL_DEBUG6  = 3'h6,
      PESC_SEL_DEBUG7  = 3'h7
   } pesc_sel_e;

endpackage

// ===== tb/pesc_config_sva.sv
`timescale 1ns/10ps
module pesc_config_sva (
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   rst_n,
   // Register port
   input wire logic [7:0]             regAddr,
   input wire logic [7:0]             regWrData,
   input wire logic                   regWrEn,
   // Watched outputs
   input wire logic                   generalPinFirstOut,
   input wire logic                   generalPinFirstOe_n,
   input wire logic                   manualWakeSel,
   input wire pesc_pkg::pesc_supply_e defaultSupplyLevel,
   input wire logic [3:0]             pllEnable_n,
   input wire logic                   holdoverMapEn,
   input wire logic [7:0]             fusePagePtr
);
   import pesc_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // Write strobes decoded per register
   logic wrEn;
   logic wrPin;
   logic wrSpare;
   logic wrFuse;
   assign wrEn    = regWrEn && (regAddr == PESC_PLL_EN_ADDR);
   assign wrPin   = regWrEn && (regAddr == PESC_PIN_CFG_ADDR);
   assign wrSpare = regWrEn && (regAddr == PESC_SPARE_ADDR);
   assign wrFuse  = regWrEn && (regAddr == PESC_FUSE_PTR_ADDR);
   // One clock domain, so one default clocking and reset
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////
   wake_select_a:
      assert property (wrEn |=> manualWakeSel == !$past(regWrData[6]))
      else $error("wake select wrong");
   supply_code_a:
      assert property (wrEn |=>
         defaultSupplyLevel == $past(regWrData[5:4]))
      else $error("supply code wrong");
   pll_enable_a:
      assert property (wrEn |=> pllEnable_n == $past(regWrData[3:0]))
      else $error("pll enables wrong");
   // Pin register lags the config register by one edge
   pin_input_a:
      assert property (wrPin && !regWrData[7] |-> ##2
         (generalPinFirstOe_n && !generalPinFirstOut))
      else $error("input pin driven");
   pin_low_a:
      assert property (wrPin && regWrData[7:4] == 4'h8 |-> ##2
         (!generalPinFirstOe_n && !generalPinFirstOut))
      else $error("code zero not low");
   hold_map_a:
      assert property (wrSpare |=> holdoverMapEn == $past(regWrData[6]))
      else $error("holdover map wrong");
   fuse_take_a:
      assert property (wrFuse && $onehot(regWrData) && !regWrData[4]
         |=> fusePagePtr == $past(regWrData))
      else $error("fuse pointer not taken");
   fuse_multi_a:
      assert property (wrFuse && !$onehot(regWrData) |=>
         $stable(fusePagePtr))
      else $error("fuse pointer not one-hot");
   fuse_page_a:
      assert property (wrFuse && regWrData[4] |=> $stable(fusePagePtr))
      else $error("reserved page taken");
   // Pointer never holds two pages or the reserved one
   fuse_legal_a:
      assert property ($onehot0(fusePagePtr) && !fusePagePtr[4])
      else $error("fuse pointer illegal");
endmodule
bind pesc_config_top pesc_config_sva i_sva (
   .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn),
   .generalPinFirstOut(generalPinFirstOut),
   .generalPinFirstOe_n(generalPinFirstOe_n),
   .manualWakeSel(manualWakeSel),
   .defaultSupplyLevel(defaultSupplyLevel),
   .pllEnable_n(pllEnable_n), .holdoverMapEn(holdoverMapEn),
   .fusePagePtr(fusePagePtr)
);

// ===== tb/pesc_host_model.sv
`timescale 1ns/10ps
module pesc_host_model (
   // Clock
   input  wire logic       clock,
   // Register port toward the device
   output      logic [7:0] regAddr,
   output      logic [7:0] regWrData,
   output      logic       regWrEn,
   output      logic       regRdEn,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid
);
   // Idle bus at time zero
   initial begin
      regAddr   = 8'h00;
      regWrData = 8'h00;
      regWrEn   = 1'b0;
      regRdEn   = 1'b0;
   end
   // Write: strobe spans one rising edge; released lines are inverted
   // so a stale value can never be mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr   = a;
      regWrData = d;
      regWrEn   = 1'b1;
      @(negedge clock);
      regWrEn   = 1'b0;
      regAddr   = ~a;
      regWrData = ~d;
   endtask
   // Read: answer stands for the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      regAddr = ~a;
      d       = regRdData;
      v       = regRdValid;
   endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import pesc_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // Clock, reset and monitor stimulus
   logic         clock;
   logic         rst_n;
   logic [15:0]  evt;
   logic [7:0]   clkMonLive;
   // Register port and device outputs
   logic [7:0]   regAddr;
   logic [7:0]   regWrData;
   logic         regWrEn;
   logic         regRdEn;
   logic [7:0]   regRdData;
   logic         regRdValid;
   logic [1:0]   pinOut;
   logic [1:0]   pinOe_n;
   logic         manualWakeSel;
   pesc_supply_e supplyLevel;
   logic [3:0]   pllEnable_n;
   logic         holdoverMapEn;
   logic [7:0]   fusePagePtr;
   // Bookkeeping
   int           errorCnt = 0;
   int           compares = 0;
   // Reset table, last entry unmapped
   localparam logic [7:0] RA [9] = '{8'h10, 8'h18, 8'h19, 8'h22,
      8'h07, 8'h08, 8'h09, 8'h0a, 8'h30};
   localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
   // Fuse writes; bad ones must leave the pointer alone
   localparam logic [7:0] FW [5] = '{8'h01, 8'h03, 8'h10, 8'h00, 8'h80};
   localparam logic [7:0] FE [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h80};
   ////////////////////////////////////////////////////////////////////
   always #4 clock = ~clock;
   pesc_host_model i_host (.clock(clock), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .regRdValid(regRdValid));
   pesc_config_top i_dut (.clock(clock), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .holdoverHoldEvt(evt[15:12]),
      .pllUnlockEvt(evt[11:8]), .clkDriftEvt(evt[7:4]),
      .clkLossEvt(evt[3:0]), .pllLiveStatus(8'h5a),
      .clkMonLive(clkMonLive), .generalPinFirstIn(1'b1),
      .generalPinFirstOut(pinOut[0]), .generalPinFirstOe_n(pinOe_n[0]),
      .generalPinSecondIn(1'b0), .generalPinSecondOut(pinOut[1]),
      .generalPinSecondOe_n(pinOe_n[1]), .manualWakeSel(manualWakeSel),
      .defaultSupplyLevel(supplyLevel), .pllEnable_n(pllEnable_n),
      .holdoverMapEn(holdoverMapEn), .fusePagePtr(fusePagePtr));
   ////////////////////////////////////////////////////////////////////
   // Value compare
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask
   // Read with valid check
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      i_host.rd(a, d, v);
      chk({7'h0, v}, 8'h01, "read valid");
      chk(d, exp, "read data");
   endtask
   // One-cycle event pulse, driven off the sampling edge
   task automatic pulse(input logic [15:0] v);
      @(negedge clock);
      evt = v;
      @(negedge clock);
      evt = 16'h0;
   endtask
   // Pin level each select code should give
   function automatic logic expPin(input logic [2:0] s, input logic p,
                                   input logic m, input logic l);
      case (s)
         3'h1:    expPin = p | m;
         3'h2:    expPin = p;
         3'h3:    expPin = m;
         3'h4:    expPin = l;
         default: expPin = 1'b0;
      endcase
   endfunction
   // Both pins as outputs through every select code
   task automatic sweep(input logic p, input logic m, input logic l);
      logic e;
      for (int c = 0; c < 8; c++) begin
         i_host.wr(PESC_PIN_CFG_ADDR, {1'b1, c[2:0], 1'b1, c[2:0]});
         @(negedge clock);
         e = expPin(c[2:0], p, m, l);
         chk({6'h0, pinOut}, {6'h0, e, e}, "pin level");
         chk({6'h0, pinOe_n}, 8'h00, "pin enable");
      end
   endtask
   // Counts, verdict, end of run
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", compares, errorCnt);
      if (errorCnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog, far beyond the roughly 130 cycles the tests need
   initial begin
      #50000;
      errorCnt++;
      giveVerdict();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      clock      = 1'b0;
      rst_n      = 1'b0;
      evt        = 16'h0;
      clkMonLive = 8'h00;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rdChk(RA[i], RV[i]);
      end
      rdChk(PESC_PLL_LIVE_ADDR, 8'h5a);
      rdChk(PESC_PIN_LEVEL_ADDR, 8'h01);
      $display("test reset done");
      // Each supply code with varied wake and enable bits
      for (int k = 0; k < 3; k++) begin
         d = {1'b0, k[0], k[1:0], 4'h5 ^ k[3:0]};
         i_host.wr(PESC_PLL_EN_ADDR, d);
         chk({7'h0, manualWakeSel}, {7'h0, ~d[6]}, "wake");
         chk({6'h0, supplyLevel}, {6'h0, d[5:4]}, "supply");
         chk({4'h0, pllEnable_n}, {4'h0, d[3:0]}, "enable");
         rdChk(PESC_PLL_EN_ADDR, d);
      end
      $display("test startup done");
      // Mask one flag, then set another and watch it stick
      i_host.wr(PESC_PLL_NOTIFY_ADDR, 8'hff);
      i_host.wr(PESC_MON_NOTIFY_ADDR, 8'hff);
      i_host.wr(PESC_PLL_MASK_ADDR, 8'hfe);
      pulse(16'h0100);
      rdChk(PESC_PLL_NOTIFY_ADDR, 8'h00);
      pulse(16'h8000);
      rdChk(PESC_PLL_NOTIFY_ADDR, 8'h80);
      $display("test flags done");
      sweep(1'b1, 1'b0, 1'b0);
      i_host.wr(PESC_PLL_NOTIFY_ADDR, 8'hff);
      pulse(16'h0010);
      clkMonLive = 8'h01;
      rdChk(PESC_MON_NOTIFY_ADDR, 8'h10);
      // Event and clear of the same flag at one edge: the set wins
      fork
         pulse(16'h0001);
         i_host.wr(PESC_MON_NOTIFY_ADDR, 8'h01);
      join
      rdChk(PESC_MON_NOTIFY_ADDR, 8'h11);
      sweep(1'b0, 1'b1, 1'b1);
      $display("test select done");
      // Input pins stay undriven and low even with a high source (code 1) selected
      i_host.wr(PESC_PIN_CFG_ADDR, 8'h11);
      // Pin register still shows the old output config for one edge
      chk({6'h0, pinOe_n}, 8'h00, "pin lag");
      @(negedge clock);
      chk({6'h0, pinOut}, 8'h00, "input level");
      chk({6'h0, pinOe_n}, 8'h03, "input enable");
      $display("test input done");
      i_host.wr(PESC_SPARE_ADDR, 8'h40);
      chk({7'h0, holdoverMapEn}, 8'h01, "map on");
      rdChk(PESC_SPARE_ADDR, 8'h40);
      i_host.wr(PESC_SPARE_ADDR, 8'h00);
      chk({7'h0, holdoverMapEn}, 8'h00, "map off");
      for (int i = 0; i < 5; i++) begin
         i_host.wr(PESC_FUSE_PTR_ADDR, FW[i]);
         chk(fusePagePtr, FE[i], "fuse");
      end
      rdChk(PESC_FUSE_PTR_ADDR, 8'h80);
      $display("test map and fuse done");
      giveVerdict();
   end
endmodule
